// ---- dv/awb_exec_chk.sv ----
/* assertions on awb_exec ports; bound to every instance */
`timescale 1ns/1ns
module awb_exec_chk import awb_pkg::*; (
   input wire logic               core_clk,
   input wire logic               sys_rst,
   input wire logic               instr_valid,
   input wire logic               w_we,
   input wire logic               f_we,
   input wire logic               z_we,
   input wire logic               z_val,
   input wire logic               done,
   input wire logic [IW_W-1:0]    instr,
   input wire logic [DATA_W-1:0]  w_rdata,
   input wire logic [DATA_W-1:0]  f_rdata,
   input wire logic [DATA_W-1:0]  w_wdata,
   input wire logic [DATA_W-1:0]  f_wdata,
   input wire logic [FADDR_W-1:0] f_waddr
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire and_hit = instr_valid && (instr[11:6] == AND_OPC);
   wire clr_hit = instr_valid && (instr[11:8] == BCLR_OPC);
   and_dest_a: assert property (
      and_hit |=> (w_we != f_we) && (f_we == $past(instr[5])))
      else $error("and steered wrongly");
   and_val_a: assert property (
      and_hit && instr[5] |=> (f_wdata == ($past(w_rdata) & $past(f_rdata)))
      && (f_waddr == $past(instr[4:0]))) else $error("and result wrong");
   and_work_a: assert property (
      and_hit && !instr[5] |=> w_wdata == ($past(w_rdata) & $past(f_rdata)))
      else $error("and working result wrong");
   clr_val_a: assert property (
      clr_hit |=> f_we && !w_we && !z_we && (f_waddr == $past(instr[4:0]))
      && (f_wdata == ($past(f_rdata) & ~(8'h01 << $past(instr[7:5])))))
      else $error("clear wrong");
   zero_flag_a: assert property (
      and_hit |=> z_we && (z_val == (($past(w_rdata) & $past(f_rdata)) == 8'h00)))
      else $error("zero flag wrong");
   no_done_a: assert property (
      !(and_hit || clr_hit) |=> !done && !w_we && !f_we && !z_we)
      else $error("done without instruction");
   done_pulse_a: assert property (
      and_hit || clr_hit |=> done) else $error("instruction did not retire");
endmodule
bind awb_exec awb_exec_chk u_chk (
   .core_clk    (core_clk),
   .sys_rst     (sys_rst),
   .instr_valid (instr_valid),
   .w_we        (w_we),
   .f_we        (f_we),
   .z_we        (z_we),
   .z_val       (z_val),
   .done        (done),
   .instr       (instr),
   .w_rdata     (w_rdata),
   .f_rdata     (f_rdata),
   .w_wdata     (w_wdata),
   .f_wdata     (f_wdata),
   .f_waddr     (f_waddr)
);

// ---- dv/awb_rf.sv ----
/* register file and working register model; fed by awb_exec writes */
`timescale 1ns/1ns
module awb_rf import awb_pkg::*; (
   input  wire logic               core_clk,
   input  wire logic               w_we,
   input  wire logic               f_we,
   input  wire logic [FADDR_W-1:0] f_addr,
   input  wire logic [FADDR_W-1:0] f_waddr,
   input  wire logic [DATA_W-1:0]  w_wdata,
   input  wire logic [DATA_W-1:0]  f_wdata,
   output logic [DATA_W-1:0]       w_rdata,
   output logic [DATA_W-1:0]       f_rdata
);
   logic [DATA_W-1:0] w, mem [32];
   assign w_rdata = w;
   assign f_rdata = mem[f_addr]; // read is combinational
   always @(posedge core_clk)
   begin
      if (w_we) w <= w_wdata;
      if (f_we) mem[f_waddr] <= f_wdata;
   end
endmodule

// ---- dv/tb.sv ----
/* testbench for awb_exec against the awb_rf model */
`timescale 1ns/1ns
module tb;
   import awb_pkg::*;
   logic core_clk = 0, sys_rst = 1, instr_valid = 0, w_we, f_we, z_we, z_val, done, dn, zw, zv;
   logic [IW_W-1:0] instr = '0;
   logic [DATA_W-1:0] w_rdata, f_rdata, w_wdata, f_wdata;
   logic [FADDR_W-1:0] f_addr, f_waddr;
   int miscompares = 0, checks = 0;
   awb_exec u_awb_exec (
      .core_clk    (core_clk),
      .sys_rst     (sys_rst),
      .instr_valid (instr_valid),
      .instr       (instr),
      .w_rdata     (w_rdata),
      .f_rdata     (f_rdata),
      .f_addr      (f_addr),
      .w_we        (w_we),
      .w_wdata     (w_wdata),
      .f_we        (f_we),
      .f_waddr     (f_waddr),
      .f_wdata     (f_wdata),
      .z_we        (z_we),
      .z_val       (z_val),
      .done        (done)
   );
   awb_rf u_awb_rf (
      .core_clk (core_clk),
      .w_we     (w_we),
      .f_we     (f_we),
      .f_addr   (f_addr),
      .f_waddr  (f_waddr),
      .w_wdata  (w_wdata),
      .f_wdata  (f_wdata),
      .w_rdata  (w_rdata),
      .f_rdata  (f_rdata)
   );
   initial forever #20 core_clk = ~core_clk;
   task chk(string n, logic [7:0] x, logic [7:0] g);
      checks++;
      if (g !== x)
      begin
         miscompares++;
         $display("unexpected %s exp %h got %h", n, x, g);
      end
   endtask
   task close_out;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one instruction; strobes sampled in the cycle after it is taken
   task op(logic [11:0] i);
      instr_valid = 1;
      instr = i;
      @(posedge core_clk) #1 instr_valid = 0;
      {dn, zw, zv} = {done, z_we, z_val};
      @(posedge core_clk) #1;
   endtask
   task t_and;
      u_awb_rf.w = 8'h17;
      u_awb_rf.mem[21] = 8'hc2;
      op(12'h175);
      chk("f", 8'h02, u_awb_rf.mem[21]);
      chk("w", 8'h17, u_awb_rf.w);
      chk("z", 8'h02, {zw, zv});
      u_awb_rf.mem[21] = 8'h28;
      op(12'h155);
      chk("w", 8'h00, u_awb_rf.w);
      chk("f", 8'h28, u_awb_rf.mem[21]);
      chk("z", 8'h03, {zw, zv});
      $display("and done");
   endtask
   task t_clr;
      for (int b = 0; b < 8; b++)
      begin
         u_awb_rf.mem[3] = 8'hff;
         op({4'h4, b[2:0], 5'h03});
         chk("f", ~(8'h01 << b), u_awb_rf.mem[3]);
         chk("flags", 8'h01, {zw, dn});
      end
      op(12'h1c3); // other opcode is ignored
      chk("done", 8'h00, dn);
      $display("clear done");
   endtask
   // and then clear on consecutive edges, no idle cycle between
   task t_b2b;
      u_awb_rf.w = 8'hf0;
      u_awb_rf.mem[7] = 8'h3c;
      u_awb_rf.mem[9] = 8'hff;
      instr_valid = 1;
      instr = 12'h147;
      @(posedge core_clk) #1 instr = 12'h4a9;
      chk("done", 8'h01, done);
      @(posedge core_clk) #1 instr_valid = 0;
      chk("done", 8'h01, done);
      @(posedge core_clk) #1;
      chk("done", 8'h00, done);
      chk("w", 8'h30, u_awb_rf.w);
      chk("f", 8'hdf, u_awb_rf.mem[9]);
      $display("back to back done");
   endtask
   initial
   begin
      repeat (10) @(posedge core_clk);
      #1 sys_rst = 0;
      t_and;
      t_clr;
      t_b2b;
      close_out;
   end
   initial
   begin
      #20000 miscompares++;
      close_out;
   end
endmodule

// ---- logic/awb_exec.sv ----
/*
 execute logic for two instructions of the core: and-with-file, which ands
 the working register with one file register and steers the result by the
 destination bit, and clear-file-bit, which forces one bit of one file
 register to zero. every other instruction word is ignored here.

 assumes of its surroundings:
 - fetch presents at most one instruction per cycle, qualified by
   instr_valid, on the same clock as this block, so no synchroniser.
 - the register file answers f_rdata for f_addr combinationally in the
   same cycle, and w_rdata always shows the current working register.
 - results come back one cycle later as write strobes that the register
   file, working register and status logic apply on the following edge.
 - a write then read of the same file register in consecutive cycles
   sees the old value unless the caller forwards; nothing here does.
 - reset is synchronous and clears every strobe.
*/
// Operation
// - on 0001 01df ffff compute working register AND addressed file register
// - destination bit 0 writes result to working register, file untouched
// - destination bit 1 writes result to file register, working untouched
// - on 0100 bbbf ffff clear bit b of file f, others kept
`timescale 1ns/1ns
module awb_exec
   import awb_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   input  wire logic               instr_valid,
   input  wire logic [IW_W-1:0]    instr,
   input  wire logic [DATA_W-1:0]  w_rdata,
   input  wire logic [DATA_W-1:0]  f_rdata,
   output logic [FADDR_W-1:0]      f_addr,
   output logic                    w_we,
   output logic [DATA_W-1:0]       w_wdata,
   output logic                    f_we,
   output logic [FADDR_W-1:0]      f_waddr,
   output logic [DATA_W-1:0]       f_wdata,
   output logic                    z_we,
   output logic                    z_val,
   output logic                    done
);
   // instruction class, one-hot, one bit per recognised instruction and one for none
   typedef enum logic [2:0]
   {
      AWB_CLS_NONE = 3'b001,
      AWB_CLS_AND  = 3'b010,
      AWB_CLS_BCLR = 3'b100
   } awb_cls_t;

   // registered write-back image and its next value
   awb_state_t        st_r;
   awb_state_t        st_nxt;
   // decode and datapath results of the current cycle
   awb_cls_t          cls;
   logic              dest_sel;
   logic [BSEL_W-1:0] bsel;
   logic [DATA_W-1:0] and_res;
   logic              and_zero;
   logic [DATA_W-1:0] clr_mask;

   // upper six bits select and-with-file; the low six are d and f
   function automatic logic match_and
   (
      input logic [IW_W-1:0] word
   );
      logic hit;
      hit = (word[AND_OPC_LSB +: AND_OPC_W] == AND_OPC);
      return hit;
   endfunction

   // upper four bits select clear-file-bit; the low eight are b and f
   function automatic logic match_bclr
   (
      input logic [IW_W-1:0] word
   );
      logic hit;
      hit = (word[BCLR_OPC_LSB +: BCLR_OPC_W] == BCLR_OPC);
      return hit;
   endfunction

   // the two opcode groups cannot overlap, so the order of the tests
   // carries no priority; an idle cycle always classifies as none
   function automatic awb_cls_t classify
   (
      input logic            valid,
      input logic [IW_W-1:0] word
   );
      awb_cls_t cls_v;
      cls_v = AWB_CLS_NONE;
      if (valid && match_and(word))
         cls_v = AWB_CLS_AND;
      else if (valid && match_bclr(word))
         cls_v = AWB_CLS_BCLR;
      return cls_v;
   endfunction

   // mask with a single zero at the selected bit position
   function automatic logic [DATA_W-1:0] clear_mask_of
   (
      input logic [BSEL_W-1:0] sel
   );
      logic [DATA_W-1:0] one_hot;
      one_hot = {{(DATA_W-1){1'b0}}, 1'b1} << sel;
      return ~one_hot;
   endfunction

   // zero test of a data word, as the zero flag sees it
   function automatic logic is_zero
   (
      input logic [DATA_W-1:0] value
   );
      return (value == '0);
   endfunction

   // the read address leaves unregistered: the register file must answer
   // in the same cycle, so this is the one output not taken from a flop
   assign f_addr   = instr[FADDR_LSB +: FADDR_W];
   // instruction fields; only meaningful for the matching class
   assign dest_sel = instr[DEST_POS];
   assign bsel     = instr[BSEL_LSB +: BSEL_W];
   // decode and datapath run every cycle, used only when a class hits
   assign cls      = classify(instr_valid, instr);
   assign and_res  = w_rdata & f_rdata;
   assign and_zero = is_zero(and_res);
   assign clr_mask = clear_mask_of(bsel);

   // next write-back image; each instruction retires in the single
   // following cycle, so back-to-back instructions need no stall
   always_comb
   begin
      st_nxt           = '0;
      st_nxt.wb.f_addr = f_addr;
      case (cls)
         AWB_CLS_AND:
         begin
            st_nxt.wb.done  = 1'b1;
            st_nxt.wb.z_we  = 1'b1;
            st_nxt.wb.z_val = and_zero;
            if (dest_sel == DEST_W)
            begin
               // result to the working register, file left alone
               st_nxt.wb.w_we   = 1'b1;
               st_nxt.wb.w_data = and_res;
            end
            else
            begin
               // result back to the file, working register left alone
               st_nxt.wb.f_we   = 1'b1;
               st_nxt.wb.f_data = and_res;
            end
         end
         AWB_CLS_BCLR:
         begin
            // read-modify-write of one file register; flags left alone
            st_nxt.wb.done   = 1'b1;
            st_nxt.wb.f_we   = 1'b1;
            st_nxt.wb.f_data = f_rdata & clr_mask;
         end
         AWB_CLS_NONE:
         begin
            // unrecognised or idle: nothing retires, all strobes stay low
            st_nxt.wb.done = 1'b0;
         end
         default:
         begin
            st_nxt.wb.done = 1'b0;
         end
      endcase
   end

   // single register stage so every output except f_addr comes from a flip-flop
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign w_we    = st_r.wb.w_we;
   assign w_wdata = st_r.wb.w_data;
   assign f_we    = st_r.wb.f_we;
   assign f_waddr = st_r.wb.f_addr;
   assign f_wdata = st_r.wb.f_data;
   assign z_we    = st_r.wb.z_we;
   assign z_val   = st_r.wb.z_val;
   assign done    = st_r.wb.done;
endmodule

// ---- logic/awb_pkg.sv ----
/*
 package for the and-with-file / clear-file-bit execute block: opcode
 patterns, field positions, widths and carrier structs.
 assumes a 12-bit instruction word and an 8-bit data path.
*/
package awb_pkg;
   localparam int IW_W          = 12;
   localparam int DATA_W        = 8;
   localparam int FADDR_W       = 5;
   localparam int BSEL_W        = 3;
   // opcode match: top six bits for and-with-file, top four for clear-bit
   localparam int AND_OPC_W     = 6;
   localparam int BCLR_OPC_W    = 4;
   localparam logic [AND_OPC_W-1:0]  AND_OPC  = 6'h05;
   localparam logic [BCLR_OPC_W-1:0] BCLR_OPC = 4'h4;
   localparam int AND_OPC_LSB   = 6;
   localparam int BCLR_OPC_LSB  = 8;
   localparam int DEST_POS      = 5;
   localparam int BSEL_LSB      = 5;
   localparam int FADDR_LSB     = 0;
   localparam logic DEST_W      = 1'b0;
   localparam logic DEST_F      = 1'b1;
   localparam logic [DATA_W-1:0] W_RST = 8'h00;

   // write requests toward the core register file and working register
   typedef struct packed {
      logic               w_we;
      logic [DATA_W-1:0]  w_data;
      logic               f_we;
      logic [FADDR_W-1:0] f_addr;
      logic [DATA_W-1:0]  f_data;
      logic               z_we;
      logic               z_val;
      logic               done;
   } awb_wb_t;

   typedef struct packed {
      awb_wb_t wb;
   } awb_state_t;
endpackage
